/* core/msg_guard.sv */
// Mode-based special-register and memory access guard
`timescale 1ns/10ps
module msg_guard (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input msg_pkg::msg_mode_t mode,
    input msg_pkg::msg_sr_req_t sr_req,
    input msg_pkg::msg_mem_req_t mem_req,
    input wire logic [7:0] unit_rdata,
    output msg_pkg::msg_sr_req_t sr_fwd,
    output msg_pkg::msg_mem_req_t mem_fwd,
    output logic [7:0] sr_rdata,
    output logic [15:0] seg_ptr,
    output logic sr_violation,
    output logic mem_violation
);
    import msg_pkg::*;

    msg_cls_t cls;
    logic [2:0] unit_idx;
    logic [7:0] unit_user_en;
    logic [7:0] unit_fw_en;
    logic [7:0] seg_en;
    logic sr_ok;
    logic mem_ok;
    logic mmu_wr;
    logic [2:0] seg_idx;
    logic in_fw;

    function automatic logic in_fw_area(input logic [15:0] a);
        in_fw_area = (a >= FW_BASE) && (a <= FW_LAST);
    endfunction

    msg_sr_class u_class (
        .addr(sr_req.addr),
        .cls(cls),
        .unit_idx(unit_idx)
    );

    // ------------------------------------------------------------------------
    // Special-register access decision
    // ------------------------------------------------------------------------
    always_comb begin
        sr_ok = 1'b0;
        case (cls)
            MSG_CLS_CORE: begin
                sr_ok = (mode == MSG_MODE_SYSTEM) || (mode == MSG_MODE_USER) || (mode == MSG_MODE_FW); // [R3]
            end
            MSG_CLS_MMU: begin
                sr_ok = (mode == MSG_MODE_SYSTEM); // [R1] [R5]
            end
            MSG_CLS_UNIT: begin
                case (mode)
                    MSG_MODE_SYSTEM: sr_ok = 1'b1; // [R2]
                    MSG_MODE_USER: sr_ok = unit_user_en[unit_idx]; // [R4]
                    MSG_MODE_FW: sr_ok = unit_fw_en[unit_idx]; // [R9]
                    default: sr_ok = 1'b0;
                endcase
            end
            default: sr_ok = 1'b0;
        endcase
    end

    assign mmu_wr = sr_req.valid && sr_req.write && sr_ok && (cls == MSG_CLS_MMU) && clk_en;

    // Forward only granted accesses
    always_comb begin
        sr_fwd = sr_req;
        sr_fwd.valid = sr_req.valid && sr_ok && (cls != MSG_CLS_MMU); // [R10]
    end

    // ------------------------------------------------------------------------
    // MMU configuration registers
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            seg_ptr <= RST_SEG_PTR; // [R8]
        end else if (mmu_wr && sr_req.addr == SR_SEG_PTR_LO) begin
            seg_ptr[7:0] <= sr_req.wdata; // [R5]
        end else if (mmu_wr && sr_req.addr == SR_SEG_PTR_HI) begin
            seg_ptr[15:8] <= sr_req.wdata; // [R5]
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            unit_user_en <= RST_UNIT_USER_EN; // [R8]
            unit_fw_en <= RST_UNIT_FW_EN;
        end else if (mmu_wr && sr_req.addr == SR_UNIT_USER_EN) begin
            unit_user_en <= sr_req.wdata; // [R4]
        end else if (mmu_wr && sr_req.addr == SR_UNIT_FW_EN) begin
            unit_fw_en <= sr_req.wdata; // [R9]
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            seg_en <= RST_SEG_EN; // [R6]
        end else if (mmu_wr && sr_req.addr == SR_SEG_EN) begin
            seg_en <= sr_req.wdata;
        end
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sr_rdata <= 8'h00;
        end else if (clk_en && sr_req.valid && !sr_req.write) begin
            if (!sr_ok) begin
                sr_rdata <= 8'h00; // [R10]
            end else if (cls != MSG_CLS_MMU) begin
                sr_rdata <= unit_rdata;
            end else begin
                case (sr_req.addr)
                    SR_SEG_PTR_LO: sr_rdata <= seg_ptr[7:0];
                    SR_SEG_PTR_HI: sr_rdata <= seg_ptr[15:8];
                    SR_UNIT_USER_EN: sr_rdata <= unit_user_en;
                    SR_UNIT_FW_EN: sr_rdata <= unit_fw_en;
                    SR_SEG_EN: sr_rdata <= seg_en;
                    default: sr_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Memory access decision
    // ------------------------------------------------------------------------
    assign seg_idx = mem_req.addr[15:SEG_SHIFT];
    assign in_fw = in_fw_area(mem_req.addr);

    always_comb begin
        mem_ok = 1'b0;
        case (mode)
            MSG_MODE_FW: mem_ok = in_fw; // [R7]
            MSG_MODE_SYSTEM: mem_ok = !in_fw;
            MSG_MODE_USER: mem_ok = !in_fw && seg_en[seg_idx]; // [R6]
            default: mem_ok = 1'b0;
        endcase
    end

    always_comb begin
        mem_fwd = mem_req;
        mem_fwd.valid = mem_req.valid && mem_ok; // [R10]
    end

    // ------------------------------------------------------------------------
    // Violation events
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sr_violation <= 1'b0;
            mem_violation <= 1'b0;
        end else if (clk_en) begin
            sr_violation <= sr_req.valid && !sr_ok; // [R10]
            mem_violation <= mem_req.valid && !mem_ok; // [R10]
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    chk_mmu_sys_only: assert property (@(posedge core_clk) disable iff (!resetn) // [R1]
        (sr_req.valid && cls == MSG_CLS_MMU && mode != MSG_MODE_SYSTEM) |-> !sr_ok)
        else $error("MMU register granted outside system mode");

    chk_unit_sys_grant: assert property (@(posedge core_clk) disable iff (!resetn) // [R2]
        (sr_req.valid && cls == MSG_CLS_UNIT && mode == MSG_MODE_SYSTEM) |-> sr_fwd.valid)
        else $error("Unit register refused in system mode");

    chk_user_core_only: assert property (@(posedge core_clk) disable iff (!resetn) // [R3]
        (sr_req.valid && mode == MSG_MODE_USER && cls == MSG_CLS_NONE) |-> !sr_fwd.valid)
        else $error("Unmapped register forwarded in user mode");

    chk_user_unit_en: assert property (@(posedge core_clk) disable iff (!resetn) // [R4]
        (sr_req.valid && cls == MSG_CLS_UNIT && mode == MSG_MODE_USER) |-> sr_fwd.valid == unit_user_en[unit_idx])
        else $error("User unit access not following enable");

    chk_ptr_guard: assert property (@(posedge core_clk) disable iff (!resetn) // [R5]
        (mode != MSG_MODE_SYSTEM) |=> $stable(seg_ptr))
        else $error("Segment pointer moved outside system mode");

    chk_reset_segs: assert property (@(posedge core_clk) // [R6]
        $rose(resetn) |-> (seg_en == RST_SEG_EN && unit_user_en == RST_UNIT_USER_EN))
        else $error("Segments not disabled after reset");

    chk_fw_partition: assert property (@(posedge core_clk) disable iff (!resetn) // [R7]
        (mem_req.valid && mode != MSG_MODE_FW && in_fw) |-> !mem_fwd.valid)
        else $error("Firewall area reached from another mode");

    chk_reset_outputs: assert property (@(posedge core_clk) // [R8]
        !resetn |-> (seg_ptr == RST_SEG_PTR && !sr_violation && !mem_violation))
        else $error("Register not at default during reset");

    chk_viol_flag: assert property (@(posedge core_clk) disable iff (!resetn) // [R10]
        (clk_en && sr_req.valid && !sr_ok) |=> sr_violation)
        else $error("Refused access raised no violation");

    sequence seq_mem_refused;
        clk_en && mem_req.valid && !mem_ok;
    endsequence

    chk_mem_viol_flag: assert property (@(posedge core_clk) disable iff (!resetn) // [R10]
        seq_mem_refused |=> mem_violation)
        else $error("Refused memory access raised no violation");

endmodule

/* core/msg_pkg.sv */
// Package of constants and carrier types for the mode-based access guard
// ----------------------------------------------------------------------------
// Overview of operation
// R1 - MMU-config registers reachable only in system mode
// R2 - System mode reaches hardware-unit registers
// R3 - User mode sees only core registers by default
// R4 - User unit access only when explicitly enabled
// R5 - Segment table pointer writable only in system
// R6 - Reset disables every memory segment; the code clears seg_en, which gates user mode only
// R7 - Firewall partition fixed, never alterable
// R8 - Reset defines every register value and attribute
// R9 - Attributes hard-wired except unit user/firewall rights
// R10 - Refused access suppressed and flagged as violation
// ----------------------------------------------------------------------------
package msg_pkg;

    // ------------------------------------------------------------------------
    // Address map of special registers (8-bit space)
    // ------------------------------------------------------------------------
    localparam logic [7:0] SR_CORE_LO = 8'h80;
    localparam logic [7:0] SR_CORE_HI = 8'h9F;
    localparam logic [7:0] SR_MMU_LO = 8'hA0;
    localparam logic [7:0] SR_MMU_HI = 8'hAF;
    localparam logic [7:0] SR_UNIT_LO = 8'hB0;
    localparam logic [7:0] SR_UNIT_HI = 8'hB7;
    // MMU-config register offsets
    localparam logic [7:0] SR_SEG_PTR_LO = 8'hA0;
    localparam logic [7:0] SR_SEG_PTR_HI = 8'hA1;
    localparam logic [7:0] SR_UNIT_USER_EN = 8'hA2;
    localparam logic [7:0] SR_UNIT_FW_EN = 8'hA3;
    localparam logic [7:0] SR_SEG_EN = 8'hA4;

    // ------------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------------
    localparam logic [15:0] RST_SEG_PTR = 16'h0000;
    localparam logic [7:0] RST_UNIT_USER_EN = 8'h00;
    localparam logic [7:0] RST_UNIT_FW_EN = 8'h00;
    localparam logic [7:0] RST_SEG_EN = 8'h00;

    // ------------------------------------------------------------------------
    // Memory layout: 8 segments of 8 KiB, fixed firewall window
    // ------------------------------------------------------------------------
    localparam int SEG_SHIFT = 13;
    localparam logic [15:0] FW_BASE = 16'hE000;
    localparam logic [15:0] FW_LAST = 16'hFFFF;

    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        MSG_MODE_SYSTEM = 2'b00,
        MSG_MODE_USER = 2'b01,
        MSG_MODE_FW = 2'b11
    } msg_mode_t;

    typedef enum logic [1:0] {
        MSG_CLS_CORE = 2'b00,
        MSG_CLS_MMU = 2'b01,
        MSG_CLS_UNIT = 2'b11,
        MSG_CLS_NONE = 2'b10
    } msg_cls_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } msg_sr_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
    } msg_mem_req_t;

endpackage

/* core/msg_sr_class.sv */
// Special-register address class decoder
`timescale 1ns/10ps
module msg_sr_class (
    input wire logic [7:0] addr,
    output msg_pkg::msg_cls_t cls,
    output logic [2:0] unit_idx
);
    import msg_pkg::*;

    // ------------------------------------------------------------------------
    // Hard-wired class per address
    // ------------------------------------------------------------------------
    always_comb begin
        cls = MSG_CLS_NONE;
        if (addr >= SR_CORE_LO && addr <= SR_CORE_HI) begin
            cls = MSG_CLS_CORE;
        end else if (addr >= SR_MMU_LO && addr <= SR_MMU_HI) begin
            cls = MSG_CLS_MMU; // [R9]
        end else if (addr >= SR_UNIT_LO && addr <= SR_UNIT_HI) begin
            cls = MSG_CLS_UNIT;
        end
    end

    assign unit_idx = addr[2:0];

endmodule

/* testbench/msg_core_regs.sv */
// Register-side model answering forwarded special-register reads
`timescale 1ns/10ps
module msg_core_regs (
    input wire logic core_clk,
    input msg_pkg::msg_sr_req_t sr_fwd,
    output logic [7:0] unit_rdata
);
    import msg_pkg::*;
    logic [7:0] idle_pat = 8'h00;
    // Pattern that moves every cycle while nothing is selected
    always_ff @(posedge core_clk) begin
        idle_pat <= idle_pat + 8'h3B;
    end
    assign unit_rdata = sr_fwd.valid ? (sr_fwd.addr ^ 8'hA5) : idle_pat;
endmodule

/* testbench/msg_guard_test.sv */
// Self-checking bench for the mode-based access guard
`timescale 1ns/10ps
module msg_guard_test;
    import msg_pkg::*;
    localparam msg_mem_req_t NO_MEM = '0;
    localparam msg_sr_req_t NO_SR = '0;
    logic core_clk = 1'b0;
    logic resetn;
    logic clk_en = 1'b1;
    logic ce_low = 1'b0;
    msg_mode_t mode = MSG_MODE_SYSTEM;
    msg_sr_req_t sr_req = '0;
    msg_mem_req_t mem_req = '0;
    logic [7:0] unit_rdata, sr_rdata, uen, fen, segen, p_rdv;
    msg_sr_req_t sr_fwd;
    msg_mem_req_t mem_fwd;
    logic [15:0] seg_ptr, exp_ptr;
    logic sr_violation, mem_violation, p_sv, p_mv, p_rd;
    int err_total = 0;
    int num_checks = 0;
    int seed = 32'heb6a_8855;
    logic [31:0] r;

    always #5 core_clk = ~core_clk;

    msg_guard dut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .mode(mode),
        .sr_req(sr_req), .mem_req(mem_req), .unit_rdata(unit_rdata), .sr_fwd(sr_fwd),
        .mem_fwd(mem_fwd), .sr_rdata(sr_rdata), .seg_ptr(seg_ptr),
        .sr_violation(sr_violation), .mem_violation(mem_violation));
    msg_core_regs u_regs (.core_clk(core_clk), .sr_fwd(sr_fwd), .unit_rdata(unit_rdata));

    // ------------------------------------------------------------------------
    // Expectations and checks
    // ------------------------------------------------------------------------
    function automatic logic sr_ok(input logic [1:0] m, input logic [7:0] a);
        if (m == 2'b10) return 1'b0;
        if (a >= SR_CORE_LO && a <= SR_CORE_HI) return 1'b1;
        if (a >= SR_MMU_LO && a <= SR_MMU_HI) return m == MSG_MODE_SYSTEM;
        if (a < SR_UNIT_LO || a > SR_UNIT_HI) return 1'b0;
        return m == MSG_MODE_SYSTEM || (m == MSG_MODE_USER && uen[a[2:0]]) || (m == MSG_MODE_FW && fen[a[2:0]]);
    endfunction

    function automatic logic mem_ok(input logic [1:0] m, input logic [15:0] a);
        if (m == 2'b10) return 1'b0;
        if (m == MSG_MODE_FW) return a >= FW_BASE;
        return a < FW_BASE && (m != MSG_MODE_USER || segen[a[15:SEG_SHIFT]]);
    endfunction

    function automatic logic [7:0] mmu_val(input logic [7:0] a);
        case (a)
            SR_SEG_PTR_LO: return exp_ptr[7:0];
            SR_SEG_PTR_HI: return exp_ptr[15:8];
            SR_UNIT_USER_EN: return uen;
            SR_UNIT_FW_EN: return fen;
            SR_SEG_EN: return segen;
            default: return 8'h00;
        endcase
    endfunction

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic do_reset();
        if (resetn === 1'b1) @(posedge core_clk);
        resetn <= 1'b0;
        clk_en <= 1'b1;
        ce_low = 1'b0;
        sr_req <= '0;
        mem_req <= '0;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        exp_ptr = RST_SEG_PTR;
        uen = RST_UNIT_USER_EN;
        fen = RST_UNIT_FW_EN;
        segen = RST_SEG_EN;
        {p_sv, p_mv, p_rd, p_rdv} = {3'b001, 8'h00};
    endtask

    // One cycle: new requests, last cycle's registered results
    task automatic step(input logic [1:0] m, input msg_sr_req_t s, input msg_mem_req_t q);
        logic sok, mok, mmu;
        @(posedge core_clk);
        mode <= msg_mode_t'(m);
        sr_req <= s;
        mem_req <= q;
        clk_en <= !ce_low;
        #1;
        chk1("sr_violation", p_sv, sr_violation);
        chk1("mem_violation", p_mv, mem_violation);
        if (p_rd) chk("sr_rdata", {8'h00, p_rdv}, {8'h00, sr_rdata});
        chk("seg_ptr", exp_ptr, seg_ptr);
        mmu = s.addr >= SR_MMU_LO && s.addr <= SR_MMU_HI;
        sok = s.valid && sr_ok(m, s.addr);
        mok = q.valid && mem_ok(m, q.addr);
        chk1("sr_fwd.valid", sok && !mmu, sr_fwd.valid);
        if (sok && !mmu) chk("sr_fwd", {s.write, s.addr, s.wdata}, {sr_fwd.write, sr_fwd.addr, sr_fwd.wdata});
        chk1("mem_fwd.valid", mok, mem_fwd.valid);
        if (mok) chk("mem_fwd", {q.write, q.addr}, {mem_fwd.write, mem_fwd.addr});
        if (!ce_low) begin
            p_sv = s.valid && !sok;
            p_mv = q.valid && !mok;
            p_rd = s.valid && !s.write;
            p_rdv = !sok ? 8'h00 : (mmu ? mmu_val(s.addr) : (s.addr ^ 8'hA5));
        end
        if (!ce_low && sok && s.write && mmu) begin
            case (s.addr)
                SR_SEG_PTR_LO: exp_ptr[7:0] = s.wdata;
                SR_SEG_PTR_HI: exp_ptr[15:8] = s.wdata;
                SR_UNIT_USER_EN: uen = s.wdata;
                SR_UNIT_FW_EN: fen = s.wdata;
                SR_SEG_EN: segen = s.wdata;
                default: ;
            endcase
        end
    endtask

    // ------------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------------
    initial begin
        do_reset();
        step(MSG_MODE_USER, NO_SR, '{1'b1, 1'b0, 16'h0000});
        step(MSG_MODE_SYSTEM, '{1'b1, 1'b1, SR_SEG_PTR_LO, 8'h34}, '{1'b1, 1'b0, FW_BASE});
        step(MSG_MODE_SYSTEM, '{1'b1, 1'b1, SR_SEG_PTR_HI, 8'h12}, '{1'b1, 1'b1, 16'hDFFF});
        step(MSG_MODE_USER, '{1'b1, 1'b1, SR_SEG_PTR_LO, 8'hFF}, '{1'b1, 1'b0, FW_BASE});
        step(MSG_MODE_FW, '{1'b1, 1'b1, SR_SEG_PTR_HI, 8'hEE}, '{1'b1, 1'b0, FW_LAST});
        step(MSG_MODE_USER, '{1'b1, 1'b0, SR_UNIT_LO, 8'h00}, NO_MEM);
        step(MSG_MODE_SYSTEM, '{1'b1, 1'b1, SR_UNIT_USER_EN, 8'h05}, NO_MEM);
        step(MSG_MODE_SYSTEM, '{1'b1, 1'b1, SR_SEG_EN, 8'h81}, NO_MEM);
        step(MSG_MODE_USER, '{1'b1, 1'b0, SR_UNIT_LO, 8'h00}, '{1'b1, 1'b0, 16'h0100});
        step(MSG_MODE_USER, '{1'b1, 1'b0, 8'hB1, 8'h00}, '{1'b1, 1'b0, 16'h2000});
        step(2'b10, '{1'b1, 1'b0, SR_CORE_LO, 8'h00}, '{1'b1, 1'b0, 16'h0000});
        step(MSG_MODE_SYSTEM, '{1'b1, 1'b1, SR_UNIT_FW_EN, 8'h02}, NO_MEM);
        step(MSG_MODE_FW, '{1'b1, 1'b0, 8'hB1, 8'h00}, NO_MEM);
        step(MSG_MODE_SYSTEM, '{1'b1, 1'b0, SR_SEG_PTR_LO, 8'h00}, NO_MEM);
        step(MSG_MODE_SYSTEM, '{1'b1, 1'b0, SR_SEG_EN, 8'h00}, NO_MEM);
        ce_low = 1'b1;
        step(MSG_MODE_SYSTEM, '{1'b1, 1'b1, SR_SEG_PTR_HI, 8'h56}, '{1'b1, 1'b0, FW_BASE});
        ce_low = 1'b0;
        step(MSG_MODE_USER, '{1'b1, 1'b0, SR_CORE_HI, 8'h00}, NO_MEM);
        $display("test corners done");
        repeat (400) begin
            r = $random(seed);
            ce_low = (r[27:25] == 3'b000);
            step(r[15:14], '{r[11] | r[12], r[10], (r[9:8] != 2'b00) ? 8'h78 + {2'b00, r[5:0]} : r[7:0],
                r[23:16]}, '{r[13], r[6], r[31:16]});
        end
        $display("test random done");
        do_reset();
        step(MSG_MODE_USER, '{1'b1, 1'b0, SR_UNIT_LO, 8'h00}, '{1'b1, 1'b0, 16'h0000});
        step(MSG_MODE_SYSTEM, NO_SR, NO_MEM);
        $display("test second reset done");
        finish_test();
    end

    initial begin
        #50000;
        err_total++;
        finish_test();
    end
endmodule
